// ==== hw/bamap_cfg.svh ====
// constants of the beam-to-analog mapper
`ifndef BAMAP_CFG_SVH
`define BAMAP_CFG_SVH

`define BAM_BEAMS      32
`define BAM_NCFG       6
`define BAM_NRANGE     8'h07
`define BAM_NFUNC      8'h07

`define BAM_I_RANGE    4'h0
`define BAM_I_FUNC     4'h1
`define BAM_I_START    4'h2
`define BAM_I_END      4'h3
`define BAM_I_DEPTH    4'h4
`define BAM_I_SMOOTH   4'h5
`define BAM_I_CMD      4'h6
`define BAM_I_STATUS   4'h7
`define BAM_I_EVAL     4'h8
`define BAM_I_NONE     4'hF
`define BAM_I_LAST     3'h5

`define BAM_A_RANGE    8'h00
`define BAM_A_FUNC     8'h04
`define BAM_A_START    8'h08
`define BAM_A_END      8'h0C
`define BAM_A_DEPTH    8'h10
`define BAM_A_SMOOTH   8'h14
`define BAM_A_CMD      8'h18
`define BAM_A_STATUS   8'h1C
`define BAM_A_EVAL     8'h20

`define BAM_CMD_TEACH  8'h01
`define BAM_CMD_RESET  8'h02
`define BAM_CMD_FACT   8'h03

`define BAM_DEF_RANGE  8'h00
`define BAM_DEF_FUNC   8'h01
`define BAM_DEF_START  8'h01
`define BAM_DEF_END    8'h20
`define BAM_DEF_DEPTH  8'h01
`define BAM_DEF_SMOOTH 8'h01

`define BAM_SPAN       13'h1000
`define BAM_FULL       12'hFFF

`endif

// ==== hw/bamap_pkg.sv ====
// types and beam scan functions of the beam-to-analog mapper
`include "bamap_cfg.svh"

package bamap_pkg;

    typedef enum logic [2:0] {
        RNG_OFF, RNG_U0_5, RNG_U0_10, RNG_U0_11, RNG_I4_20, RNG_I0_20, RNG_I0_24
    } bamap_range_e;

    typedef enum logic [2:0] {
        FN_OFF, FN_FIRST_INT, FN_FIRST_CLR, FN_LAST_INT, FN_LAST_CLR, FN_TOT_INT, FN_TOT_CLR
    } bamap_func_e;

    typedef enum logic [1:0] {
        ST_LOAD = 2'h0,
        ST_RUN  = 2'h1,
        ST_FACT = 2'h3
    } bamap_state_e;

    typedef struct packed {
        logic       wr;
        logic [2:0] sel;
        logic [7:0] data;
    } bamap_pnl_s;

    typedef logic [5:0] bamap_beam_t;

    function automatic bamap_beam_t bamap_ones(input logic [`BAM_BEAMS-1:0] v);
        bamap_beam_t n;
        n = '0;
        for (int i = 0; i < `BAM_BEAMS; i++) n = n + bamap_beam_t'(v[i]);
        return n;
    endfunction

    // beam numbers count from 1; zero means no such beam
    function automatic bamap_beam_t bamap_first(input logic [`BAM_BEAMS-1:0] v);
        bamap_beam_t n;
        n = '0;
        for (int i = `BAM_BEAMS - 1; i >= 0; i--) if (v[i]) n = bamap_beam_t'(i + 1);
        return n;
    endfunction

    function automatic bamap_beam_t bamap_last(input logic [`BAM_BEAMS-1:0] v);
        bamap_beam_t n;
        n = '0;
        for (int i = 0; i < `BAM_BEAMS; i++) if (v[i]) n = bamap_beam_t'(i + 1);
        return n;
    endfunction

endpackage

// ==== hw/bamap_nvstore.sv ====
// retained configuration store, one word per setting
`timescale 1ns/1ps
`include "bamap_cfg.svh"

module bamap_nvstore (
    input  wire logic       ref_clk_in, // device clock
    input  wire logic       we_in,      // store one word
    input  wire logic [2:0] waddr_in,   // setting index
    input  wire logic [7:0] wdata_in,   // value to store
    input  wire logic [2:0] raddr_in,   // setting index to read
    output logic [7:0]      rdata_out,  // stored value
    output logic            rvalid_out  // word was ever written
);
    // no reset: contents must survive a power cycle
    logic [8:0] mem_q [`BAM_NCFG];

    always_ff @(posedge ref_clk_in) begin
        if (we_in) begin
            mem_q[waddr_in] <= {1'b1, wdata_in};
        end
    end

    assign rdata_out  = mem_q[raddr_in][7:0];
    assign rvalid_out = mem_q[raddr_in][8];

    a_nv_store : assert property (@(posedge ref_clk_in)
        we_in |=> mem_q[$past(waddr_in)] == {1'b1, $past(wdata_in)})
        else $error("store word not retained");

endmodule // bamap_nvstore

// ==== hw/bamap_filter.sv ====
// beam state debounce over measurement cycles, then smoothing gate
`timescale 1ns/1ps
`include "bamap_cfg.svh"

module bamap_filter
    import bamap_pkg::*;
(
    input  wire logic                  ref_clk_in, // device clock
    input  wire logic                  rst_in,     // async reset, active high
    input  wire logic                  meas_in,    // new measurement cycle
    input  wire logic [`BAM_BEAMS-1:0] beams_in,   // 1 = interrupted
    input  wire logic [7:0]            depth_in,   // cycles that must agree
    input  wire logic [7:0]            smooth_in,  // least interrupted count
    output logic [`BAM_BEAMS-1:0]      beams_out   // accepted beam states
);
    logic [`BAM_BEAMS-1:0] prev_q;
    logic [`BAM_BEAMS-1:0] stable_q;
    logic [7:0]            agree_q;
    logic [7:0]            agree_d;

    always_comb begin
        agree_d = 8'h01;
        if (beams_in == prev_q) agree_d = (agree_q == 8'hFF) ? agree_q : agree_q + 8'h01;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_q  <= '0;
            agree_q <= 8'h00;
        end else if (meas_in) begin
            prev_q  <= beams_in;
            agree_q <= agree_d;
        end
    end

    // depth 0 behaves as 1: every cycle updates
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stable_q <= '0;
        end else if (meas_in && agree_d >= depth_in) begin
            if ({2'b00, bamap_ones(beams_in)} < smooth_in) stable_q <= '0;
            else stable_q <= beams_in;
        end
    end

    assign beams_out = stable_q;

    a_depth_hold : assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (meas_in && beams_in != prev_q && depth_in > 8'h01) |=> $stable(beams_out))
        else $error("unstable beams passed the filter");

    a_smooth_gate : assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ($changed(beams_out) && beams_out != '0)
            |-> {2'b00, bamap_ones(beams_out)} >= $past(smooth_in))
        else $error("too few beams treated as object");

endmodule // bamap_filter

// ==== hw/bamap_top.sv ====
// beam-to-analog mapper: settings, apb slave, evaluation and code mapping
`timescale 1ns/1ps
`include "bamap_cfg.svh"

// Operation
// - the output range is one of off, 0-5 V, 0-10 V, 0-11 V, 4-20 mA, 0-20 mA, 0-24 mA.
// - the output follows off or one of six first, last or total beam functions.
// - the curve runs from the start beam to the end beam, by default 1 and 32.
// - an end beam below the start beam inverts the curve.
// - the 12-bit span of 4096 codes is divided by the beam count to give the step.
// - on a standard curve all beams free gives the lowest code, end beam interrupted gives full scale; inverted, all free gives full scale.
// - every setting is kept in retained storage and reloaded after power-up, except a remote write in the same cycle as a panel write.
// - the last written setting wins, the panel winning over remote writes.
// - commands are teach, reset and factory settings, the last restoring defaults.
// - results update only after filter-depth measurement cycles agree.
// - fewer interrupted beams than the smoothing count are not an object.
module bamap_top
    import bamap_pkg::*;
(
    input  wire logic                  ref_clk_in,    // 100 MHz device clock
    input  wire logic                  rst_in,        // async reset, active high
    input  wire logic                  psel_in,       // apb select
    input  wire logic                  penable_in,    // apb access phase
    input  wire logic                  pwrite_in,     // apb write
    input  wire logic [7:0]            paddr_in,      // apb byte address
    input  wire logic [31:0]           pwdata_in,     // apb write data
    output logic [31:0]                prdata_out,    // apb read data
    output logic                       pready_out,    // apb ready
    output logic                       pslverr_out,   // apb error
    input  wire bamap_pnl_s            pnl_in,        // local panel write
    output logic                       pnl_ready_out, // panel writes taken
    input  wire logic                  meas_in,       // measurement cycle done
    input  wire logic [`BAM_BEAMS-1:0] beams_in,      // 1 = beam interrupted
    output logic [11:0]                dac_code_out,  // converter code
    output bamap_range_e               dac_range_out, // selected output range
    output logic                       teach_out      // teach request pulse
);
    localparam logic [7:0] DEF [`BAM_NCFG] = '{
        `BAM_DEF_RANGE, `BAM_DEF_FUNC, `BAM_DEF_START,
        `BAM_DEF_END, `BAM_DEF_DEPTH, `BAM_DEF_SMOOTH
    };

    bamap_state_e                   st_q;
    bamap_state_e                   st_d;
    logic [2:0]                     ld_idx_q;
    logic [`BAM_NCFG-1:0][7:0]      cfg_w;
    logic                           pready_q;
    logic                           pslverr_q;
    logic [31:0]                    prdata_q;
    logic [31:0]                    rd_mux;
    logic                           pnl_rdy_q;
    logic                           last_pnl_q;
    logic                           teach_q;
    bamap_beam_t                    eval_q;
    bamap_beam_t                    eval_d;
    logic [11:0]                    code_q;
    logic [11:0]                    code_d;
    bamap_range_e                   rng_q;
    logic [`BAM_BEAMS-1:0]          stable;
    logic                           nv_we;
    logic [2:0]                     nv_waddr;
    logic [7:0]                     nv_wdata;
    logic [7:0]                     nv_rdata;
    logic                           nv_rvalid;

    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] r;
        r = `BAM_I_NONE;
        case (a)
            `BAM_A_RANGE:  r = `BAM_I_RANGE;
            `BAM_A_FUNC:   r = `BAM_I_FUNC;
            `BAM_A_START:  r = `BAM_I_START;
            `BAM_A_END:    r = `BAM_I_END;
            `BAM_A_DEPTH:  r = `BAM_I_DEPTH;
            `BAM_A_SMOOTH: r = `BAM_I_SMOOTH;
            `BAM_A_CMD:    r = `BAM_I_CMD;
            `BAM_A_STATUS: r = `BAM_I_STATUS;
            `BAM_A_EVAL:   r = `BAM_I_EVAL;
            default:       r = `BAM_I_NONE;
        endcase
        return r;
    endfunction

    // request decode
    logic       apb_req;
    logic       apb_new;
    logic       apb_acc;
    logic [3:0] apb_idx;
    logic       apb_wr_cfg;
    logic       apb_cmd;
    logic       run;
    logic       pnl_wr;
    logic       pnl_cmd;
    logic [2:0] pnl_sel;
    logic [7:0] pnl_dat;
    logic       cmd_go;
    logic [7:0] cmd_val;
    logic       fact_go;

    assign run        = (st_q == ST_RUN);
    assign apb_req    = psel_in && penable_in;
    assign apb_new    = apb_req && !pready_q;
    assign apb_acc    = apb_req && pready_q;
    assign apb_idx    = reg_index(paddr_in);
    assign apb_wr_cfg = apb_acc && pwrite_in && apb_idx < `BAM_I_CMD && run;
    assign apb_cmd    = apb_acc && pwrite_in && apb_idx == `BAM_I_CMD && run;
    assign pnl_sel    = pnl_in.sel;
    assign pnl_dat    = pnl_in.data;
    assign pnl_wr     = pnl_in.wr && run && {1'b0, pnl_sel} < `BAM_I_CMD;
    assign pnl_cmd    = pnl_in.wr && run && {1'b0, pnl_sel} == `BAM_I_CMD;
    assign cmd_go     = pnl_cmd || apb_cmd;
    assign cmd_val    = pnl_cmd ? pnl_dat : pwdata_in[7:0];
    assign fact_go    = cmd_go && cmd_val == `BAM_CMD_FACT;

    // load from storage after reset, factory restore, normal run
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_LOAD: if (ld_idx_q == `BAM_I_LAST) st_d = ST_RUN;
            ST_RUN: begin
                if (fact_go) st_d = ST_FACT;
                else if (cmd_go && cmd_val == `BAM_CMD_RESET) st_d = ST_LOAD;
            end
            ST_FACT: if (ld_idx_q == `BAM_I_LAST) st_d = ST_RUN;
            default: st_d = ST_LOAD;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= ST_LOAD;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ld_idx_q <= 3'h0;
        end else if (!run && ld_idx_q != `BAM_I_LAST) begin
            ld_idx_q <= ld_idx_q + 3'h1;
        end else begin
            ld_idx_q <= 3'h0;
        end
    end

    // one register per setting; restore beats writers, panel beats remote
    for (genvar g = 0; g < `BAM_NCFG; g++) begin : g_cfg
        logic [7:0] val_q;
        always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
                val_q <= DEF[g];
            end else if (st_q == ST_LOAD && ld_idx_q == 3'(g)) begin
                if (nv_rvalid) val_q <= nv_rdata;
                else val_q <= DEF[g];
            end else if (fact_go) begin
                val_q <= DEF[g];
            end else if (pnl_wr && pnl_sel == 3'(g)) begin
                val_q <= pnl_dat;
            end else if (apb_wr_cfg && apb_idx == 4'(g)) begin
                val_q <= pwdata_in[7:0];
            end
        end
        assign cfg_w[g] = val_q;
    end

    // accepted changes are also written to the retained store, except a remote write in the same cycle as a panel write
    always_comb begin
        nv_we    = 1'b0;
        nv_waddr = ld_idx_q;
        nv_wdata = DEF[ld_idx_q];
        if (st_q == ST_FACT) begin
            nv_we = 1'b1;
        end else if (pnl_wr) begin
            nv_we    = 1'b1;
            nv_waddr = pnl_sel;
            nv_wdata = pnl_dat;
        end else if (apb_wr_cfg) begin
            nv_we    = 1'b1;
            nv_waddr = apb_idx[2:0];
            nv_wdata = pwdata_in[7:0];
        end
    end

    bamap_nvstore u_nv (
        .ref_clk_in (ref_clk_in),
        .we_in      (nv_we),
        .waddr_in   (nv_waddr),
        .wdata_in   (nv_wdata),
        .raddr_in   (ld_idx_q),
        .rdata_out  (nv_rdata),
        .rvalid_out (nv_rvalid)
    );

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_pnl_q <= 1'b0;
        end else if (pnl_wr) begin
            last_pnl_q <= 1'b1;
        end else if (apb_wr_cfg) begin
            last_pnl_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            teach_q   <= 1'b0;
            pnl_rdy_q <= 1'b0;
        end else begin
            teach_q   <= cmd_go && cmd_val == `BAM_CMD_TEACH;
            pnl_rdy_q <= (st_d == ST_RUN);
        end
    end

    // apb: one wait state, answers only while running
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (apb_idx < `BAM_I_CMD) rd_mux = {24'h00_0000, cfg_w[apb_idx[2:0]]};
        else if (apb_idx == `BAM_I_STATUS)
            rd_mux = {16'h0000, 1'b0, last_pnl_q, st_q, code_q};
        else if (apb_idx == `BAM_I_EVAL) rd_mux = {26'h000_0000, eval_q};
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            // wait for the load to finish so a read never catches a stale setting
            pready_q  <= apb_new && st_d == ST_RUN && run;
            pslverr_q <= apb_new && st_d == ST_RUN && run && apb_idx == `BAM_I_NONE;
            if (apb_new && !pwrite_in) prdata_q <= rd_mux;
            else prdata_q <= 32'h0000_0000;
        end
    end

    bamap_filter u_filt (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .meas_in    (meas_in),
        .beams_in   (beams_in),
        .depth_in   (cfg_w[`BAM_I_DEPTH]),
        .smooth_in  (cfg_w[`BAM_I_SMOOTH]),
        .beams_out  (stable)
    );

    // evaluation function
    logic fn_ok;
    logic rng_ok;
    assign fn_ok  = cfg_w[`BAM_I_FUNC] < `BAM_NFUNC && cfg_w[`BAM_I_FUNC] != 8'h00;
    assign rng_ok = cfg_w[`BAM_I_RANGE] < `BAM_NRANGE && cfg_w[`BAM_I_RANGE] != 8'h00;

    always_comb begin
        eval_d = '0;
        case (cfg_w[`BAM_I_FUNC][2:0])
            FN_FIRST_INT: eval_d = bamap_first(stable);
            FN_FIRST_CLR: eval_d = bamap_first(~stable);
            FN_LAST_INT:  eval_d = bamap_last(stable);
            FN_LAST_CLR:  eval_d = bamap_last(~stable);
            FN_TOT_INT:   eval_d = bamap_ones(stable);
            FN_TOT_CLR:   eval_d = bamap_ones(~stable);
            default:      eval_d = '0;
        endcase
        if (!fn_ok) eval_d = '0;
    end

    // curve mapping; the divider is combinational, counts are small
    logic        inv;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  ev8;
    logic [8:0]  span_n;
    logic [12:0] step;
    logic [8:0]  offs;
    logic [21:0] raw;
    logic [11:0] sat;

    assign ev8    = {2'b00, eval_q};
    assign inv    = cfg_w[`BAM_I_END] < cfg_w[`BAM_I_START];
    assign lo     = inv ? cfg_w[`BAM_I_END] : cfg_w[`BAM_I_START];
    assign hi     = inv ? cfg_w[`BAM_I_START] : cfg_w[`BAM_I_END];
    assign span_n = {1'b0, hi} - {1'b0, lo} + 9'h001;
    assign step   = `BAM_SPAN / {4'h0, span_n};

    always_comb begin
        if (ev8 == 8'h00 || ev8 < lo) offs = 9'h000;
        else if (ev8 > hi) offs = span_n;
        else offs = {1'b0, ev8} - {1'b0, lo} + 9'h001;
        raw = {13'h0000, offs} * {9'h000, step};
        // the last beam must reach full scale even when 4096 does not divide evenly
        sat = (raw >= 22'(`BAM_SPAN) || offs == span_n) ? `BAM_FULL : raw[11:0];
        code_d = inv ? `BAM_FULL - sat : sat;
        if (!rng_ok || !fn_ok) code_d = 12'h000;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            eval_q <= '0;
            code_q <= 12'h000;
            rng_q  <= RNG_OFF;
        end else begin
            eval_q <= eval_d;
            code_q <= code_d;
            rng_q  <= rng_ok ? bamap_range_e'(cfg_w[`BAM_I_RANGE][2:0]) : RNG_OFF;
        end
    end

    assign prdata_out    = prdata_q;
    assign pready_out    = pready_q;
    assign pslverr_out   = pslverr_q;
    assign pnl_ready_out = pnl_rdy_q;
    assign dac_code_out  = code_q;
    assign dac_range_out = rng_q;
    assign teach_out     = teach_q;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic active;
    assign active = rng_ok && fn_ok;

    sequence s_fact_done;
        st_q == ST_FACT && ld_idx_q == `BAM_I_LAST;
    endsequence

    a_range_off_zero : assert property (!rng_ok
            |=> code_q == 12'h000 && rng_q == RNG_OFF)
        else $error("off range did not force zero");
    a_func_off_zero : assert property (!fn_ok |=> eval_q == '0)
        else $error("off function gave a value");
    a_factory_defaults : assert property (s_fact_done |=> st_q == ST_RUN
            && cfg_w[`BAM_I_START] == `BAM_DEF_START && cfg_w[`BAM_I_END] == `BAM_DEF_END)
        else $error("factory restore left wrong curve");
    a_inverted_free : assert property (active && inv && eval_q == '0
            |=> code_q == `BAM_FULL)
        else $error("inverted curve not full when free");
    a_first_step : assert property (active && !inv && ev8 == lo && lo != 8'h00
            && span_n > 9'h001 |=> code_q == $past(step[11:0]))
        else $error("first beam step wrong");
    a_standard_free : assert property (active && !inv && eval_q == '0
            |=> code_q == 12'h000)
        else $error("standard curve not zero when free");
    a_end_full : assert property (active && !inv && eval_q != '0 && ev8 >= hi
            |=> code_q == `BAM_FULL)
        else $error("end beam not full scale");
    a_panel_wins : assert property (pnl_wr && apb_wr_cfg && {1'b0, pnl_sel} == apb_idx
            |=> cfg_w[$past(pnl_sel)] == $past(pnl_dat))
        else $error("remote write beat panel");
    // back-to-back panel teach commands may keep the pulse high
    a_teach_pulse : assert property (cmd_go && cmd_val == `BAM_CMD_TEACH |=> teach_q)
        else $error("teach pulse missing");
    a_teach_quiet : assert property (!(cmd_go && cmd_val == `BAM_CMD_TEACH)
            |=> !teach_q)
        else $error("teach pulse without command");

endmodule // bamap_top

// ==== testbench/bamap_plc_model.sv ====
// plc analog input model that accepts a code once it has settled
`timescale 1ns/1ps
module bamap_plc_model #(
    parameter int SETTLE = 4 // steady cycles before a code counts
) (
    input  wire logic        ref_clk_in, // device clock
    input  wire logic        rst_in,     // async reset, active high
    input  wire logic [11:0] code_in,    // converter code seen
    output logic [11:0]      value_out,  // last settled value
    output logic             valid_out   // value_out has settled
);
    logic [11:0] last_q;
    int          cnt_q;
    // a full-scale step may still be slewing, so only a steady code is taken
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_q    <= 12'h000;
            cnt_q     <= 0;
            value_out <= 12'h000;
            valid_out <= 1'b0;
        end else begin
            last_q <= code_in;
            if (code_in != last_q) begin
                cnt_q <= 0;
            end else if (cnt_q < SETTLE) begin
                cnt_q <= cnt_q + 1;
            end
            if (cnt_q >= SETTLE) begin
                value_out <= last_q;
                valid_out <= 1'b1;
            end
        end
    end
endmodule // bamap_plc_model

// ==== testbench/tb_beam_to_analog_output_mapper.sv ====
// self-checking bench of the beam-to-analog mapper
`timescale 1ns/1ps
`include "bamap_cfg.svh"
module tb_beam_to_analog_output_mapper import bamap_pkg::*;;
    logic         clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, meas = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0000_0000, beams = 32'h0000_0000, prdata, rd;
    logic         pready, pslverr, pnl_rdy, teach, plc_ok, er, teach_seen = 1'b0;
    logic [11:0]  code, plc_val;
    bamap_range_e rng;
    bamap_pnl_s   pnl = '0;
    int           errors = 0, checks_done = 0;
    logic [11:0]  fexp [7] = '{12'h000, 12'h180, 12'h080, 12'h280, 12'hfff, 12'h180, 12'he80};

    bamap_top dut (.ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pnl_in(pnl), .pnl_ready_out(pnl_rdy),
        .meas_in(meas), .beams_in(beams), .dac_code_out(code), .dac_range_out(rng),
        .teach_out(teach));
    bamap_plc_model plc (.ref_clk_in(clk), .rst_in(rst), .code_in(code),
        .value_out(plc_val), .valid_out(plc_ok));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (teach === 1'b1) teach_seen <= 1'b1;

    task automatic final_report();
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // one measurement, then long enough for the reader to settle
    task automatic beam(input logic [31:0] v, input logic [11:0] exp);
        @(posedge clk);
        beams <= v;
        meas  <= 1'b1;
        @(posedge clk);
        meas <= 1'b0;
        repeat (12) @(posedge clk);
        check({20'h0_0000, plc_val}, {20'h0_0000, exp});
    endtask

    task automatic t_defaults();
        rdchk(`BAM_A_START, 32'h0000_0001);
        rdchk(`BAM_A_END, 32'h0000_0020);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check({rd[30:0], er}, 32'h0000_0001);
    endtask
    task automatic t_ranges();
        for (int i = 6; i >= 0; i--) begin
            apb(1'b1, `BAM_A_RANGE, 32'(i));
            repeat (2) @(posedge clk);
            check({29'h0, rng}, 32'(i));
        end
    endtask
    task automatic t_curve();
        apb(1'b1, `BAM_A_RANGE, 32'h0000_0004);
        beam(32'h0000_0000, 12'h000);
        beam(32'h8000_0000, 12'hfff);
        beam(32'h0000_8000, 12'h800);
        check({31'h0, plc_ok}, 32'h0000_0001);
        for (int f = 0; f < 7; f++) begin
            apb(1'b1, `BAM_A_FUNC, 32'(f));
            beam(32'h0000_001c, fexp[f]);
        end
        apb(1'b1, `BAM_A_FUNC, 32'h0000_0001);
        apb(1'b1, `BAM_A_START, 32'h0000_0020);
        apb(1'b1, `BAM_A_END, 32'h0000_0001);
        beam(32'h0000_0000, 12'hfff);
        beam(32'h8000_0000, 12'h000);
    endtask
    task automatic t_saturate();
        apb(1'b1, `BAM_A_START, 32'h0000_0005);
        apb(1'b1, `BAM_A_END, 32'h0000_0008);
        beam(32'h0000_0200, 12'hfff);
        beam(32'h0000_0004, 12'h000);
        beam(32'h0000_0020, 12'h800);
        apb(1'b1, `BAM_A_RANGE, 32'h0000_0000);
        beam(32'h0000_0020, 12'h000);
    endtask
    task automatic t_filter();
        apb(1'b1, `BAM_A_RANGE, 32'h0000_0004);
        apb(1'b1, `BAM_A_END, 32'h0000_0020);
        apb(1'b1, `BAM_A_START, 32'h0000_0001);
        beam(32'h0000_0000, 12'h000);
        apb(1'b1, `BAM_A_DEPTH, 32'h0000_0003);
        beam(32'h0000_8000, 12'h000);
        beam(32'h0000_8000, 12'h000);
        beam(32'h0000_8000, 12'h800);
        apb(1'b1, `BAM_A_DEPTH, 32'h0000_0001);
        apb(1'b1, `BAM_A_SMOOTH, 32'h0000_0003);
        beam(32'h0000_000c, 12'h000);
        beam(32'h0000_001c, 12'h180);
        rdchk(`BAM_A_EVAL, 32'h0000_0003);
    endtask
    task automatic t_config();
        apb(1'b1, `BAM_A_START, 32'h0000_0007);
        // panel strobe lands in the same cycle as a remote write of the same setting
        fork
            apb(1'b1, `BAM_A_START, 32'h0000_000b);
            begin
                repeat (3) @(posedge clk);
                pnl <= '{wr: 1'b1, sel: 3'h2, data: 8'h09};
                @(posedge clk);
                pnl.wr <= 1'b0;
            end
        join
        rdchk(`BAM_A_START, 32'h0000_0009);
        rdchk(`BAM_A_STATUS, 32'h0000_5000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check({31'h0, pnl_rdy}, 32'h0000_0000);
        rdchk(`BAM_A_START, 32'h0000_0009);
        check({31'h0, pnl_rdy}, 32'h0000_0001);
        check({31'h0, teach_seen}, 32'h0000_0000);
        apb(1'b1, `BAM_A_CMD, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check({31'h0, teach_seen}, 32'h0000_0001);
        apb(1'b1, `BAM_A_CMD, 32'h0000_0003);
        rdchk(`BAM_A_START, 32'h0000_0001);
        rdchk(`BAM_A_SMOOTH, 32'h0000_0001);
        apb(1'b1, `BAM_A_START, 32'h0000_000c);
        apb(1'b1, `BAM_A_CMD, 32'h0000_0002);
        rdchk(`BAM_A_START, 32'h0000_000c);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_ranges();
        t_curve();
        t_saturate();
        t_filter();
        t_config();
        final_report();
    end
endmodule // tb_beam_to_analog_output_mapper
